/* File: hdl/subtract_word_unit.sv */
// subtract word instruction family: sequencing, indicators, apb
`timescale 1ns/1ps
`default_nettype none
module subtract_word_unit
  import sub_word_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] instr_addr,
  output logic busy,
  output logic done,
  output chk_type check,
  output ind_type ind,
  output logic mem_req,
  output mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_bad,
  output logic agu_req,
  output agu_cmd_type agu_cmd,
  input wire logic agu_ack,
  input wire logic [15:0] agu_ea
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic form_type decode(input logic [15:0] w);
    decode = F_NONE;
    if (w[15:11] == OP_REG && w[4:0] == FN_SUB) decode = F_RR;
    if (w[15:11] == OP_REG && w[4:0] == FN_BORROW) decode = F_RWC;
    if (w[15:11] == OP_RS && w[2:0] == FN_RS) decode = F_RS;
    if (w[15:11] == OP_LONG && w[3:0] == FN_LONG) decode = F_LONG;
    if (w[15:11] == OP_SS && w[1:0] == FN_SS) decode = F_SS;
    if (w[15:11] == OP_IMR && w[4:2] == FN_IMR_HI && !w[0]) decode = F_IMR;
    if (w[15:11] == OP_IMS && w[3:0] == FN_IMS) decode = F_IMS;
  endfunction

  // addressing mode of the first or second storage operand
  function automatic logic [1:0] mode_of(input logic [15:0] w,
                                         input form_type f,
                                         input logic second);
    if (f == F_SS) mode_of = second ? w[4:3] : w[6:5];
    else mode_of = w[5:4];
  endfunction

  // base register of the first or second storage operand
  function automatic logic [2:0] base_of(input logic [15:0] w,
                                         input form_type f,
                                         input logic second);
    if (f == F_SS) base_of = second ? {1'b0, w[8:7]} : {1'b0, w[10:9]};
    else base_of = {1'b0, w[7:6]};
  endfunction

  // appended words an instruction carries
  function automatic logic [1:0] words_of(input logic [15:0] w,
                                          input form_type f);
    logic [1:0] m1;
    logic [1:0] m2;
    m1 = mode_of(w, f, 1'b0);
    m2 = mode_of(w, f, 1'b1);
    unique case (f)
      F_IMR, F_LONG: words_of = 2'd1;
      F_RS: words_of = {1'b0, m1[1]};
      F_IMS: words_of = 2'd1 + {1'b0, m1[1]};
      F_SS: words_of = {1'b0, m1[1]} + {1'b0, m2[1]};
      default: words_of = 2'd0;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  state_type state;
  form_type form;
  logic [15:0] ir;
  logic [15:0] ia;
  logic [15:0] wbuf [3];
  logic [1:0] nw;
  logic [1:0] wi;
  logic agn;
  logic [15:0] ea1;
  logic [15:0] ea2;
  logic [15:0] sa;
  logic [15:0] sb;
  logic [1:0] inc_mask;
  chk_type chk_pend;
  chk_type chk_sticky;
  logic [15:0] last_result;
  form_type in_form;
  logic [1:0] in_words;
  logic [2:0] ra_idx;
  logic [15:0] ra;
  logic [15:0] rb;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [15:0] wr_data;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic op_bin;
  logic [15:0] diff;
  logic sub_carry;
  logic sub_ovf;
  logic [15:0] long_base;
  logic dest_mem;
  logic inc_second;
  logic apb_wr;

  assign in_form = decode(instr_word);
  assign in_words = words_of(instr_word, in_form);
  assign inc_second = !inc_mask[0];
  assign apb_wr = psel && penable && pwrite && pready;
  // register field zero means no register joins the long address
  assign long_base = wbuf[0] + (ir[7:5] == 3'h0 ? 16'h0000 : ra);

  // result goes to storage for these forms
  always_comb begin
    dest_mem = (form == F_SS) || (form == F_IMS);
    if (form == F_RS) dest_mem = ir[3];
  end

  // ****************************************
  // register file and subtractor
  // ****************************************
  gp_reg_file #(.WIDTH(16), .DEPTH(8)) regs (
    .pclk(pclk),
    .presetn(presetn),
    .rd_a_idx(ra_idx),
    .rd_a(ra),
    .rd_b_idx(ir[10:8]),
    .rd_b(rb),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data)
  );

  word_subtractor #(.WIDTH(16)) sub (
    .minuend(op_a),
    .subtrahend(op_b),
    .borrow_in(op_bin),
    .diff(diff),
    .carry(sub_carry),
    .overflow(sub_ovf)
  );

  // read port a follows the step in progress
  always_comb begin
    ra_idx = ir[7:5];
    // long form keeps the full second register field for its base
    if (state == S_RESOLVE && form != F_LONG)
      ra_idx = base_of(ir, form, 1'b0);
    // second base is wanted while the first address comes back
    if (state == S_AGU) ra_idx = base_of(ir, form, 1'b1);
    if (state == S_INC) ra_idx = base_of(ir, form, inc_second);
  end

  // operand steering per form; port b always reads the first field
  always_comb begin
    op_a = ra;
    op_b = rb;
    op_bin = 1'b0;
    unique case (form)
      F_RWC: op_bin = ind.carry;
      F_IMR: begin
        op_a = rb;
        op_b = wbuf[0];
      end
      F_LONG: begin
        op_a = rb;
        op_b = sa;
      end
      F_RS: begin
        op_a = ir[3] ? sa : rb;
        op_b = ir[3] ? rb : sa;
      end
      F_IMS: begin
        op_a = sa;
        op_b = wbuf[0];
      end
      F_SS: begin
        op_a = sb;
        op_b = sa;
      end
      default: op_a = ra;
    endcase
  end

  // register writes: results in exec, base bumps at the end
  always_comb begin
    wr_en = 1'b0;
    wr_idx = ir[7:5];
    wr_data = diff;
    if (state == S_EXEC && !dest_mem) begin
      wr_en = 1'b1;
      if (form == F_LONG || form == F_RS) wr_idx = ir[10:8];
    end
    if (state == S_INC && inc_mask != 2'b00) begin
      wr_en = 1'b1;
      wr_idx = base_of(ir, form, inc_second);
      wr_data = ra + WORD_STEP;
    end
  end

  // ****************************************
  // instruction sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      form <= F_NONE;
      ir <= WORD_RESET;
      ia <= WORD_RESET;
      wbuf <= '{default: WORD_RESET};
      nw <= 2'd0;
      wi <= 2'd0;
      agn <= 1'b0;
      ea1 <= WORD_RESET;
      ea2 <= WORD_RESET;
      sa <= WORD_RESET;
      sb <= WORD_RESET;
      inc_mask <= 2'b00;
      chk_pend <= CHK_RESET;
      busy <= 1'b0;
      done <= 1'b0;
      check <= CHK_RESET;
      mem_req <= 1'b0;
      mem_cmd <= '0;
      agu_req <= 1'b0;
      agu_cmd <= '0;
    end else begin
      done <= 1'b0;
      if (mem_ack) mem_req <= 1'b0;
      if (agu_ack) agu_req <= 1'b0;
      unique case (state)
        S_IDLE: if (start) begin
          ir <= instr_word;
          form <= in_form;
          ia <= instr_addr + WORD_STEP;
          nw <= in_words;
          wi <= 2'd0;
          agn <= 1'b0;
          chk_pend <= CHK_RESET;
          busy <= 1'b1;
          inc_mask <= 2'b00;
          if (mode_of(instr_word, in_form, 1'b0) == MODE_POSTINC &&
              in_form inside {F_RS, F_IMS, F_SS}) inc_mask[0] <= 1'b1;
          if (mode_of(instr_word, in_form, 1'b1) == MODE_POSTINC &&
              in_form == F_SS) inc_mask[1] <= 1'b1;
          if (in_form == F_RR || in_form == F_RWC) state <= S_EXEC;
          else if (in_form == F_NONE) state <= S_INC;
          else if (in_words != 2'd0) begin
            state <= S_FETCH;
            mem_req <= 1'b1;
            mem_cmd <= '{we: 1'b0, addr: instr_addr + WORD_STEP, wdata: '0};
          end else state <= S_RESOLVE;
        end
        S_FETCH: if (mem_ack) begin
          if (mem_bad) begin
            chk_pend.inv_addr <= 1'b1;
            inc_mask <= 2'b00;
            state <= S_INC;
          end else begin
            wbuf[wi] <= mem_rdata;
            wi <= wi + 2'd1;
            ia <= ia + WORD_STEP;
            if (wi + 2'd1 < nw) begin
              mem_req <= 1'b1;
              mem_cmd <= '{we: 1'b0, addr: ia + WORD_STEP, wdata: '0};
            end else state <= S_RESOLVE;
          end
        end
        S_RESOLVE: begin
          if (form == F_IMR) state <= S_EXEC;
          else if (form == F_LONG) begin
            if (long_base[0]) begin
              chk_pend.spec <= 1'b1;
              state <= S_INC;
            end else begin
              mem_req <= 1'b1;
              mem_cmd <= '{we: 1'b0, addr: long_base, wdata: '0};
              ea1 <= long_base;
              state <= ir[4] ? S_IND : S_RD1;
            end
          end else begin
            // displacement is the last appended word of the operand
            agu_req <= 1'b1;
            agu_cmd <= '{base: ra, mode: mode_of(ir, form, 1'b0),
                         disp: (form == F_IMS) ? wbuf[1] : wbuf[0]};
            state <= S_AGU;
          end
        end
        S_IND: if (mem_ack) begin
          if (mem_bad) begin
            chk_pend.inv_addr <= 1'b1;
            state <= S_INC;
          end else if (mem_rdata[0]) begin
            chk_pend.spec <= 1'b1;
            state <= S_INC;
          end else begin
            ea1 <= mem_rdata;
            mem_req <= 1'b1;
            mem_cmd <= '{we: 1'b0, addr: mem_rdata, wdata: '0};
            state <= S_RD1;
          end
        end
        S_AGU: if (agu_ack) begin
          if (agu_ea[0]) begin
            chk_pend.spec <= 1'b1;
            inc_mask <= 2'b00;
            state <= S_INC;
          end else if (!agn && form == F_SS) begin
            ea1 <= agu_ea;
            agn <= 1'b1;
            agu_req <= 1'b1;
            agu_cmd <= '{base: ra, mode: mode_of(ir, form, 1'b1),
                         disp: wbuf[{1'b0, ir[6]}]};
          end else begin
            if (agn) ea2 <= agu_ea;
            else ea1 <= agu_ea;
            mem_req <= 1'b1;
            mem_cmd <= '{we: 1'b0, addr: agn ? ea1 : agu_ea, wdata: '0};
            state <= S_RD1;
          end
        end
        S_RD1: if (mem_ack) begin
          if (mem_bad) begin
            chk_pend.inv_addr <= 1'b1;
            inc_mask <= 2'b00;
            state <= S_INC;
          end else begin
            sa <= mem_rdata;
            if (form == F_SS) begin
              mem_req <= 1'b1;
              mem_cmd <= '{we: 1'b0, addr: ea2, wdata: '0};
              state <= S_RD2;
            end else state <= S_EXEC;
          end
        end
        S_RD2: if (mem_ack) begin
          if (mem_bad) begin
            // operand 2 bad: only the first base still steps
            chk_pend.inv_addr <= 1'b1;
            inc_mask <= inc_mask & 2'b01;
            state <= S_INC;
          end else begin
            sb <= mem_rdata;
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (dest_mem) begin
            mem_req <= 1'b1;
            mem_cmd <= '{we: 1'b1, addr: (form == F_SS) ? ea2 : ea1,
                         wdata: diff};
            state <= S_WR;
          end else state <= S_INC;
        end
        S_WR: if (mem_ack) begin
          if (mem_bad) chk_pend.inv_addr <= 1'b1;
          state <= S_INC;
        end
        S_INC: begin
          // one base register bump per cycle, then hand back
          if (inc_mask[0]) inc_mask[0] <= 1'b0;
          else if (inc_mask[1]) inc_mask[1] <= 1'b0;
          else begin
            busy <= 1'b0;
            done <= 1'b1;
            check <= chk_pend;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // indicators
  // ****************************************
  // instruction update wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind <= IND_RESET;
    end else if (state == S_EXEC) begin
      ind.carry <= sub_carry;
      ind.overflow <= sub_ovf;
      ind.negative <= diff[15];
      if (form == F_RWC) begin
        ind.zero <= ind.zero && (diff == 16'h0000);
      end else begin
        ind.even <= !diff[0];
        ind.zero <= (diff == 16'h0000);
      end
    end else if (apb_wr && paddr == ADDR_IND) begin
      ind <= pwdata[4:0];
    end
  end

  // last difference, visible to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_result <= WORD_RESET;
    else if (state == S_EXEC) last_result <= diff;
  end

  // sticky checks; a new check wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_sticky <= CHK_RESET;
    end else begin
      if (apb_wr && paddr == ADDR_CHK) chk_sticky <= chk_sticky & ~pwdata[1:0];
      if (state == S_INC && inc_mask == 2'b00) begin
        if (chk_pend.spec) chk_sticky.spec <= 1'b1;
        if (chk_pend.inv_addr) chk_sticky.inv_addr <= 1'b1;
      end
    end
  end

  // ****************************************
  // apb slave, one access cycle, no wait
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          ADDR_IND: prdata <= {27'h0, ind};
          ADDR_CHK: prdata <= {30'h0, chk_sticky};
          ADDR_RES: prdata <= {16'h0, last_result};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: hdl/sub_word_pkg.sv */
// shared constants and types of the subtract word unit
package sub_word_pkg;

  // ****************************************
  // instruction field values
  // ****************************************
  localparam logic [4:0] OP_REG = 5'h0E;
  localparam logic [4:0] OP_LONG = 5'h0D;
  localparam logic [4:0] OP_RS = 5'h19;
  localparam logic [4:0] OP_SS = 5'h15;
  localparam logic [4:0] OP_IMR = 5'h0F;
  localparam logic [4:0] OP_IMS = 5'h08;
  localparam logic [4:0] FN_SUB = 5'h0A;
  localparam logic [4:0] FN_BORROW = 5'h0B;
  localparam logic [2:0] FN_RS = 3'h7;
  localparam logic [3:0] FN_LONG = 4'hF;
  localparam logic [1:0] FN_SS = 2'h1;
  localparam logic [3:0] FN_IMS = 4'hE;
  localparam logic [2:0] FN_IMR_HI = 3'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [7:0] ADDR_IND = 8'h00;
  localparam logic [7:0] ADDR_CHK = 8'h04;
  localparam logic [7:0] ADDR_RES = 8'h08;
  localparam logic [4:0] IND_RESET = 5'h00;
  localparam logic [1:0] CHK_RESET = 2'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ****************************************
  // carriers and encodings
  // ****************************************
  typedef struct packed {
    logic carry;
    logic overflow;
    logic even;
    logic negative;
    logic zero;
  } ind_type;

  typedef struct packed {
    logic spec;
    logic inv_addr;
  } chk_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_cmd_type;

  typedef struct packed {
    logic [15:0] base;
    logic [1:0] mode;
    logic [15:0] disp;
  } agu_cmd_type;

  typedef enum logic [2:0] {
    F_NONE, F_RR, F_RWC, F_RS, F_LONG, F_SS, F_IMR, F_IMS
  } form_type;

  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_RESOLVE, S_IND, S_AGU, S_RD1, S_RD2,
    S_EXEC, S_WR, S_INC
  } state_type;

endpackage

/* File: hdl/word_subtractor.sv */
// 16-bit two's complement subtractor with carry and overflow
`timescale 1ns/1ps
`default_nettype none
module word_subtractor #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] minuend,
  input wire logic [WIDTH-1:0] subtrahend,
  input wire logic borrow_in,
  output logic [WIDTH-1:0] diff,
  output logic carry,
  output logic overflow
);

  logic [WIDTH:0] wide;
  logic borrow;

  // borrow out of the top bit lands in the extra bit
  always_comb begin
    wide = {1'b0, minuend} - {1'b0, subtrahend} - {{WIDTH{1'b0}}, borrow_in};
    diff = wide[WIDTH-1:0];
    borrow = wide[WIDTH];
    // signs differ and result sign left the minuend's: out of range
    overflow = (minuend[WIDTH-1] != subtrahend[WIDTH-1]) &&
               (diff[WIDTH-1] != minuend[WIDTH-1]);
    // on overflow carry shows the complement of the stored sign
    carry = overflow ? ~diff[WIDTH-1] : borrow;
  end

endmodule
`default_nettype wire

/* File: hdl/gp_reg_file.sv */
// general register file, flip-flop storage with two read ports
`timescale 1ns/1ps
`default_nettype none
module gp_reg_file #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [$clog2(DEPTH)-1:0] rd_a_idx,
  output logic [WIDTH-1:0] rd_a,
  input wire logic [$clog2(DEPTH)-1:0] rd_b_idx,
  output logic [WIDTH-1:0] rd_b,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data
);

  logic [WIDTH-1:0] regs [DEPTH];

  // single write port, cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        regs[i] <= '0;
      end
    end else if (wr_en) begin
      regs[wr_idx] <= wr_data;
    end
  end

  // read ports are combinational
  assign rd_a = regs[rd_a_idx];
  assign rd_b = regs[rd_b_idx];

endmodule
`default_nettype wire

/* File: dv/swu_props.sv */
// assertion checker for the subtract word unit
`timescale 1ns/1ps
`default_nettype none
module swu_props
  import sub_word_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [15:0] instr_word,
  input wire logic busy,
  input wire logic done,
  input wire chk_type check,
  input wire ind_type ind,
  input wire logic mem_req,
  input wire mem_cmd_type mem_cmd,
  input wire logic mem_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic reg_op, rwc_op, even0, zero0;
  // form and entry flags kept from the edge that takes an instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_op <= 1'b0;
      rwc_op <= 1'b0;
      even0 <= 1'b0;
      zero0 <= 1'b0;
    end else if (start && !busy) begin
      reg_op <= instr_word[15:11] == OP_REG;
      rwc_op <= instr_word[15:11] == OP_REG && instr_word[4:0] == FN_BORROW;
      even0 <= ind.even;
      zero0 <= ind.zero;
    end
  end
  property p_reg_done;
    start && !busy && instr_word[15:11] == OP_REG && instr_word[4:1] == 4'h5
      |-> ##3 done;
  endproperty
  a_reg_done: assert property (p_reg_done) else $error("reg form late");
  property p_reg_nomem;
    busy && reg_op |-> !mem_req;
  endproperty
  a_reg_nomem: assert property (p_reg_nomem) else $error("reg form used storage");
  property p_reg_nochk;
    done && reg_op |-> check == 2'h0;
  endproperty
  a_reg_nochk: assert property (p_reg_nochk) else $error("reg form check");
  property p_rwc_even;
    done && rwc_op |-> ind.even == even0;
  endproperty
  a_rwc_even: assert property (p_rwc_even) else $error("even changed");
  property p_rwc_zero;
    done && rwc_op && !zero0 |-> !ind.zero;
  endproperty
  a_rwc_zero: assert property (p_rwc_zero) else $error("zero set");
  property p_ovf_carry;
    done && check == 2'h0 && ind.overflow |-> ind.carry != ind.negative;
  endproperty
  a_ovf_carry: assert property (p_ovf_carry) else $error("ovf carry");
  property p_zero_flags;
    done && check == 2'h0 && !rwc_op && ind.zero |-> ind.even && !ind.negative;
  endproperty
  a_zero_flags: assert property (p_zero_flags) else $error("zero flags");
  property p_even_addr;
    mem_req |-> !mem_cmd.addr[0];
  endproperty
  a_even_addr: assert property (p_even_addr) else $error("odd access");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_cmd);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("request dropped");
endmodule
bind subtract_word_unit swu_props u_props (.pclk(pclk), .presetn(presetn),
  .start(start), .instr_word(instr_word), .busy(busy), .done(done),
  .check(check), .ind(ind), .mem_req(mem_req), .mem_cmd(mem_cmd),
  .mem_ack(mem_ack));
`default_nettype wire

/* File: dv/swu_store_model.sv */
// storage and address unit model facing the subtract word unit
`timescale 1ns/1ps
`default_nettype none
module swu_store_model
  import sub_word_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire mem_cmd_type mem_cmd,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  output logic mem_bad,
  input wire logic agu_req,
  input wire agu_cmd_type agu_cmd,
  output logic agu_ack,
  output logic [15:0] agu_ea
);
  logic [15:0] mem [0:255];
  logic [1:0] waited;
  logic slow;
  // answers alternate fast and slow; words above 0x1FF are invalid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_bad <= 1'b0;
      waited <= 2'h0;
      slow <= 1'b0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && waited == {slow, slow}) begin
      mem_ack <= 1'b1;
      mem_bad <= |mem_cmd.addr[15:9];
      mem_rdata <= mem[mem_cmd.addr[8:1]];
      if (mem_cmd.we && !(|mem_cmd.addr[15:9])) mem[mem_cmd.addr[8:1]] <= mem_cmd.wdata;
      waited <= 2'h0;
      slow <= !slow;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // no stale data once released
      waited <= waited + ((mem_req && !mem_ack) ? 2'h1 : 2'h0);
    end
  end
  // address unit: base plus displacement, one cycle late
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agu_ack <= 1'b0;
      agu_ea <= 16'h0000;
    end else begin
      agu_ack <= agu_req && !agu_ack;
      // modes 00 and 01 use the bare base; a stale word must not leak in
      agu_ea <= agu_ack ? ~agu_ea :
        agu_cmd.base + (agu_cmd.mode[1] ? agu_cmd.disp : 16'h0000);
    end
  end
endmodule
`default_nettype wire

/* File: dv/subtract_word_unit_bench.sv */
// self-checking bench of the subtract word unit
`timescale 1ns/1ps
`default_nettype none
module subtract_word_unit_bench;
  import sub_word_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, start = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, busy, done, mem_req, mem_ack, mem_bad;
  logic agu_req, agu_ack, err;
  logic [15:0] instr_word = 16'h0000, instr_addr = 16'h0040, mem_rdata, agu_ea;
  chk_type check;
  ind_type ind;
  mem_cmd_type mem_cmd;
  agu_cmd_type agu_cmd;
  int errors = 0, tests_run = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  subtract_word_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .start(start),
    .instr_word(instr_word), .instr_addr(instr_addr), .busy(busy),
    .done(done), .check(check), .ind(ind), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_bad(mem_bad), .agu_req(agu_req), .agu_cmd(agu_cmd),
    .agu_ack(agu_ack), .agu_ea(agu_ea));
  swu_store_model mem_m (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_bad(mem_bad), .agu_req(agu_req), .agu_cmd(agu_cmd),
    .agu_ack(agu_ack), .agu_ea(agu_ea));
  task automatic cmp(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // apb transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one instruction at 0x40 with two appended words
  task automatic run(input logic [15:0] iw, w1, w2, input logic [1:0] ck,
    input logic [15:0] res, input logic [4:0] fl);
    mem_m.mem[8'h20] = iw;
    mem_m.mem[8'h21] = w1;
    mem_m.mem[8'h22] = w2;
    @(posedge pclk);
    start <= 1'b1;
    instr_word <= iw;
    @(posedge pclk);
    start <= 1'b0;
    while (done !== 1'b1) @(posedge pclk);
    cmp("check", {30'h0, ck}, {30'h0, check});
    cmp("busy", 32'h0, {31'h0, busy});
    if (ck == 2'h0) begin
      apb(1'b0, ADDR_RES, 32'h0);
      cmp("result", {16'h0, res}, rd);
      apb(1'b0, ADDR_IND, 32'h0);
      cmp("ind", {27'h0, fl}, rd);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    mem_m.mem[8'h40] = 16'h0010;
    mem_m.mem[8'h48] = 16'hFFF9;
    mem_m.mem[8'h49] = 16'h0090;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_IND, 32'h0);
    cmp("ind reset", {27'h0, IND_RESET}, rd);
    apb(1'b0, 8'h0C, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, err});
    $display("test apb done");
    // loads: zero register minus the immediate
    run({OP_IMR, 3'd0, 3'd1, 5'h00}, 16'hFFFD, 16'h0, 2'h0, 16'h0003, 5'h10);
    run({OP_IMR, 3'd0, 3'd2, 5'h00}, 16'hFFFB, 16'h0, 2'h0, 16'h0005, 5'h10);
    run({OP_IMR, 3'd0, 3'd3, 5'h00}, 16'hFF80, 16'h0, 2'h0, 16'h0080, 5'h14);
    run({OP_IMR, 3'd0, 3'd4, 5'h00}, 16'h8000, 16'h0, 2'h0, 16'h8000, 5'h0E);
    run({OP_REG, 3'd1, 3'd2, FN_SUB}, 16'h0, 16'h0, 2'h0, 16'h0002, 5'h04);
    run({OP_REG, 3'd1, 3'd4, FN_SUB}, 16'h0, 16'h0, 2'h0, 16'h7FFD, 5'h18);
    run({OP_REG, 3'd2, 3'd2, FN_SUB}, 16'h0, 16'h0, 2'h0, 16'h0000, 5'h05);
    run({OP_REG, 3'd1, 3'd2, FN_BORROW}, 16'h0, 16'h0, 2'h0, 16'hFFFD, 5'h16);
    run({OP_REG, 3'd1, 3'd2, FN_BORROW}, 16'h0, 16'h0, 2'h0, 16'hFFF9, 5'h06);
    $display("test register forms done");
    run({OP_RS, 3'd1, 2'd3, 2'h0, 1'b1, FN_RS}, 16'h0, 16'h0, 2'h0, 16'h000D, 5'h00);
    cmp("store", 32'h000D, {16'h0, mem_m.mem[8'h40]});
    run({OP_RS, 3'd1, 2'd3, 2'h0, 1'b0, FN_RS}, 16'h0, 16'h0, 2'h0, 16'hFFF6, 5'h16);
    cmp("source", 32'h000D, {16'h0, mem_m.mem[8'h40]});
    run({OP_LONG, 3'd2, 3'd0, 1'b0, FN_LONG}, 16'h0090, 16'h0, 2'h0, 16'h0000, 5'h05);
    run({OP_LONG, 3'd2, 3'd0, 1'b1, FN_LONG}, 16'h0092, 16'h0, 2'h0, 16'h0007, 5'h10);
    run({OP_LONG, 3'd2, 3'd3, 1'b0, FN_LONG}, 16'h0010, 16'h0, 2'h0, 16'h000E, 5'h14);
    run({OP_IMS, 3'd0, 2'd3, 2'h0, FN_IMS}, 16'h0005, 16'h0, 2'h0, 16'h0008, 5'h04);
    run({OP_IMS, 3'd0, 2'd0, 2'h2, FN_IMS}, 16'h0001, 16'h0090, 2'h0, 16'hFFF8, 5'h06);
    cmp("ims store", 32'hFFF8, {16'h0, mem_m.mem[8'h48]});
    run({OP_SS, 2'd3, 2'd0, 2'h1, 2'h2, 1'b0, FN_SS}, 16'h0090, 16'h0,
      2'h0, 16'hFFF0, 5'h06);
    cmp("ss store", 32'hFFF0, {16'h0, mem_m.mem[8'h48]});
    // first base was stepped by two: copy it out through an immediate
    run({OP_IMR, 3'd3, 3'd5, 5'h00}, 16'h0, 16'h0, 2'h0, 16'h0082,
      5'h04);
    $display("test storage forms done");
    run({OP_LONG, 3'd2, 3'd0, 1'b0, FN_LONG}, 16'h0091, 16'h0, 2'h2, 16'h0, 5'h0);
    apb(1'b0, ADDR_CHK, 32'h0);
    cmp("chk spec", 32'h2, rd);
    apb(1'b1, ADDR_CHK, 32'h2);
    apb(1'b0, ADDR_CHK, 32'h0);
    cmp("chk clear", 32'h0, rd);
    run({OP_LONG, 3'd2, 3'd0, 1'b0, FN_LONG}, 16'h4000, 16'h0, 2'h1, 16'h0, 5'h0);
    $display("test checks done");
    final_report();
  end
endmodule
`default_nettype wire
